// [rtl/scd_top.sv]
// Contract
// - Modulator runs at half the master clock, one bit per two master cycles.
// - Source select pin low uses the external clock, high the internal oscillator.
// - With internal oscillator, clock output bit tristates or drives the clock pin.
// - Decimation ratio is modulator rate over data rate; one word per N samples.
// - Each channel uses a sinc3 filter, cube of (1-z^-N)/(1-z^-1).
// - After a step, output settles only after three output periods.
// - One three-bit data-rate field sets the ratio of all eight channels.
// - Response has notches at the data rate and multiples, scaling with master clock.
// - Each channel holds its own gain: only 1, 2, 4, 8 or 12.
// - Reference select resets to 4 V; clearing it selects 2.4 V.
// - Eight independent modulator and filter paths, sampled simultaneously.
// - Internal oscillator gives a nominal 2.048 MHz master clock.
// - Seven output rates 64 down to 1 kSPS, ratios 16 to 1024.
`timescale 1ns/10ps
module scd_top #(
  parameter int CH_NUM = scd_pkg::CH_NUM
) (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_in,
  input  wire logic [scd_pkg::ADDR_W-1:0]  avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [31:0]                 avs_writedata_in,
  input  wire logic [3:0]                  avs_byteenable_in,
  output logic      [31:0]                 avs_readdata_out,
  output logic                             avs_waitrequest_out,
  input  wire logic                        clock_source_select_pin_in,
  input  wire logic                        clk_pin_in,
  output logic                             clk_pin_out,
  output logic                             clk_pin_oe_out,
  input  wire logic [CH_NUM-1:0]           mod_bit_in,
  output logic      [3*CH_NUM-1:0]         pga_gain_out,
  output logic                             reference_high_select_out,
  output logic                             sample_strobe_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]        sel_sync, next_sel_sync;
  logic [2:0]        ext_sync, next_ext_sync;   // Third stage only feeds edge detection
  logic [CH_NUM-1:0] mod_s1, mod_s2, next_mod_s1, next_mod_s2;

  // Two flops before any logic looks at a pin
  always_comb
  begin
    next_sel_sync = {sel_sync[0], clock_source_select_pin_in};
    next_ext_sync = {ext_sync[1:0], clk_pin_in};
    next_mod_s1   = mod_bit_in;
    next_mod_s2   = mod_s1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      sel_sync <= '0;
      ext_sync <= '0;
      mod_s1   <= '0;
      mod_s2   <= '0;
    end
    else
    begin
      sel_sync <= next_sel_sync;
      ext_sync <= next_ext_sync;
      mod_s1   <= next_mod_s1;
      mod_s2   <= next_mod_s2;
    end
  end

  // ----------------------------------------------------------------
  // Master clock selection and modulator rate
  // ----------------------------------------------------------------
  logic [scd_pkg::NCO_W-1:0] nco, next_nco;
  logic                      osc_prev, next_osc_prev;
  logic                      mod_phase, next_mod_phase;
  logic                      mod_tick, next_mod_tick;
  logic                      clk_en;
  logic                      next_clk_pin, next_clk_oe;
  logic                      int_sel, master_tick, osc_level;

  // Moving the source pin mid-run can give one odd master period, so the
  // first words after a switch are not to be trusted by the host
  // Oscillator is modelled as a phase accumulator; its MSB is the square wave
  always_comb
  begin
    next_nco       = nco + scd_pkg::NCO_INC;
    osc_level      = nco[scd_pkg::NCO_W-1];
    next_osc_prev  = osc_level;
    int_sel        = sel_sync[1];
    master_tick    = int_sel ? (osc_level & ~osc_prev)
                             : (ext_sync[1] & ~ext_sync[2]);
    next_mod_phase = master_tick ? ~mod_phase : mod_phase;
    next_mod_tick  = master_tick & mod_phase;                       // Every second master edge
    next_clk_oe    = int_sel & clk_en;                              // Ignored when external
    next_clk_pin   = next_clk_oe & osc_level;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      nco            <= '0;
      osc_prev       <= 1'b0;
      mod_phase      <= 1'b0;
      mod_tick       <= 1'b0;
      clk_pin_out    <= 1'b0;
      clk_pin_oe_out <= 1'b0;
    end
    else
    begin
      nco            <= next_nco;
      osc_prev       <= next_osc_prev;
      mod_phase      <= next_mod_phase;
      mod_tick       <= next_mod_tick;
      clk_pin_out    <= next_clk_pin;
      clk_pin_oe_out <= next_clk_oe;
    end
  end

  // ----------------------------------------------------------------
  // Global decimation timing and settling
  // ----------------------------------------------------------------
  logic [2:0]               rate;
  logic                     rate_change;
  logic [scd_pkg::DEC_W-1:0] dec_cnt, next_dec_cnt, dec_last;
  logic                     dec_tick, next_dec_tick;
  logic [1:0]               settle_cnt, next_settle_cnt;
  logic                     next_strobe;

  // A write that changes the rate restarts filters and settling, so the status flag drops at once
  // One counter drives every channel, so all convert on the same edge
  always_comb
  begin
    dec_last        = scd_pkg::DEC_W'((1 << (scd_pkg::N_MIN_LOG2 + int'(rate))) - 1);
    next_dec_cnt    = dec_cnt;
    next_dec_tick   = 1'b0;
    next_settle_cnt = settle_cnt;
    if (mod_tick)
    begin
      if (dec_cnt >= dec_last)
      begin
        next_dec_cnt  = '0;
        next_dec_tick = 1'b1;                                       // One word per N samples
      end
      else
        next_dec_cnt = dec_cnt + 1'b1;
    end
    if (dec_tick && settle_cnt != scd_pkg::SETTLE_OUTPUTS)
      next_settle_cnt = settle_cnt + 1'b1;                          // Three words to flush the filter
    if (rate_change)
    begin
      next_dec_cnt    = '0;
      next_settle_cnt = '0;                                         // New ratio restarts settling
    end
    next_strobe = dec_tick;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      dec_cnt           <= '0;
      dec_tick          <= 1'b0;
      settle_cnt        <= '0;
      sample_strobe_out <= 1'b0;
    end
    else
    begin
      dec_cnt           <= next_dec_cnt;
      dec_tick          <= next_dec_tick;
      settle_cnt        <= next_settle_cnt;
      sample_strobe_out <= next_strobe;
    end
  end

  // ----------------------------------------------------------------
  // Channel filters
  // ----------------------------------------------------------------
  logic [scd_pkg::OUT_W-1:0] chan_data [CH_NUM];

  // Separate path per channel sharing the global ticks
  for (genvar ch = 0; ch < CH_NUM; ch++)
  begin : g_chan
    scd_sinc3 u_sinc3 (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .clear_in    (rate_change),
      .mod_tick_in (mod_tick),
      .dec_tick_in (dec_tick),
      .bit_in      (mod_s2[ch]),
      .rate_in     (rate),
      .sample_out  (chan_data[ch])
    );
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave and registers
  // ----------------------------------------------------------------
  logic                 ack, next_ack;
  logic [31:0]          next_rdata;
  logic [2:0]           next_rate;
  logic                 next_clk_en, next_ref_hi;
  logic [2:0]           gain [CH_NUM];
  logic [2:0]           next_gain [CH_NUM];
  logic                 wr_go;
  logic [2:0]           wr_code;

  // Every field lives in byte lane 0, so a write without that lane is dropped;
  // status and data offsets are read-only and ignore writes
  // Answer one cycle after a request; waitrequest low for exactly that cycle
  always_comb
  begin
    next_ack    = (avs_read_in | avs_write_in) & ~ack;
    wr_go       = avs_write_in & ack & avs_byteenable_in[0];
    next_rdata  = avs_readdata_out;
    next_rate   = rate;
    next_clk_en = clk_en;
    next_ref_hi = reference_high_select_out;
    next_gain   = gain;
    rate_change = 1'b0;
    wr_code     = avs_writedata_in[scd_pkg::CHSET_GAIN_LSB +: 3];
    if (avs_read_in && !ack)
    begin
      next_rdata = '0;
      if (avs_address_in == scd_pkg::OFS_CFG1)
      begin
        next_rdata[scd_pkg::CFG1_RATE_LSB +: 3] = rate;
        next_rdata[scd_pkg::CFG1_CLKEN_BIT]    = clk_en;
      end
      else if (avs_address_in == scd_pkg::OFS_CFG2)
        next_rdata[scd_pkg::CFG2_REFHI_BIT] = reference_high_select_out;
      else if (avs_address_in == scd_pkg::OFS_STAT)
      begin
        next_rdata[scd_pkg::STAT_SETTLED] = (settle_cnt == scd_pkg::SETTLE_OUTPUTS);
        next_rdata[scd_pkg::STAT_CLKSRC]  = int_sel;
      end
      for (int i = 0; i < CH_NUM; i++)
      begin
        if (avs_address_in == scd_pkg::OFS_CHSET_BASE + 8'(4 * i))
          next_rdata[scd_pkg::CHSET_GAIN_LSB +: 3] = gain[i];
        if (avs_address_in == scd_pkg::OFS_DATA_BASE + 8'(4 * i))
          next_rdata = {{(32 - scd_pkg::OUT_W){chan_data[i][scd_pkg::OUT_W-1]}}, chan_data[i]};
      end
    end
    if (wr_go)
    begin
      if (avs_address_in == scd_pkg::OFS_CFG1)
      begin
        if (avs_writedata_in[scd_pkg::CFG1_RATE_LSB +: 3] <= scd_pkg::RATE_MAX)  // Reserved code ignored
        begin
          next_rate   = avs_writedata_in[scd_pkg::CFG1_RATE_LSB +: 3];
          rate_change = (next_rate != rate);
        end
        next_clk_en = avs_writedata_in[scd_pkg::CFG1_CLKEN_BIT];
      end
      else if (avs_address_in == scd_pkg::OFS_CFG2)
        next_ref_hi = avs_writedata_in[scd_pkg::CFG2_REFHI_BIT];
      for (int i = 0; i < CH_NUM; i++)
        if (avs_address_in == scd_pkg::OFS_CHSET_BASE + 8'(4 * i) && scd_pkg::gain_legal(wr_code))
          next_gain[i] = wr_code;                                            // Illegal code keeps old
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      ack                       <= 1'b0;
      avs_waitrequest_out       <= 1'b1;
      avs_readdata_out          <= '0;
      rate                      <= scd_pkg::RATE_RST;
      clk_en                    <= scd_pkg::CLKEN_RST;
      reference_high_select_out <= scd_pkg::REFHI_RST;                       // 4 V after reset
      for (int i = 0; i < CH_NUM; i++)
        gain[i] <= 3'(scd_pkg::GAIN_RST);
    end
    else
    begin
      ack                       <= next_ack;
      avs_waitrequest_out       <= ~next_ack;
      avs_readdata_out          <= next_rdata;
      rate                      <= next_rate;
      clk_en                    <= next_clk_en;
      reference_high_select_out <= next_ref_hi;
      gain                      <= next_gain;
    end
  end

  // Gain codes go to the analog front end as a flat bus
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      pga_gain_out <= '0;
    else
      for (int i = 0; i < CH_NUM; i++)
        pga_gain_out[3*i +: 3] <= next_gain[i];
  end

endmodule : scd_top

// [rtl/scd_pkg.sv]
package scd_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam longint unsigned SYS_CLK_HZ = 64'd200_000_000;
  localparam longint unsigned OSC_HZ     = 64'd2_048_000;    // Nominal internal oscillator
  localparam int              NCO_W      = 32;
  // Phase step of the oscillator model per system clock
  localparam logic [NCO_W-1:0] NCO_INC   = NCO_W'((OSC_HZ << NCO_W) / SYS_CLK_HZ);

  // ----------------------------------------------------------------
  // Datapath shape
  // ----------------------------------------------------------------
  localparam int          CH_NUM       = 8;
  localparam int          RATE_W       = 3;
  localparam int          DEC_W        = 10;                  // Holds the largest ratio minus one
  localparam int          N_MIN_LOG2   = 4;                   // Ratio 16 at the fastest rate
  localparam int          ACC_W        = 32;
  localparam int          OUT_W        = 24;
  localparam int          ALIGN_SHIFT  = 11;                  // Full scale at ratio 16 onto bit 23
  localparam int          OCTAVE_SHIFT = 3;                   // Third order: three bits per octave
  localparam logic [2:0]  RATE_MAX     = 3'h6;
  localparam logic [1:0]  SETTLE_OUTPUTS = 2'h3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG1       = 8'h00;
  localparam logic [7:0] OFS_CFG2       = 8'h04;
  localparam logic [7:0] OFS_STAT       = 8'h08;
  localparam logic [7:0] OFS_CHSET_BASE = 8'h10;
  localparam logic [7:0] OFS_DATA_BASE  = 8'h40;
  localparam int         ADDR_W         = 8;

  localparam int         CFG1_RATE_LSB  = 0;
  localparam int         CFG1_CLKEN_BIT = 5;
  localparam int         CFG2_REFHI_BIT = 4;
  localparam int         CHSET_GAIN_LSB = 4;
  localparam int         STAT_SETTLED   = 0;
  localparam int         STAT_CLKSRC    = 1;

  localparam logic [2:0] RATE_RST       = 3'h6;
  localparam logic       CLKEN_RST      = 1'b0;
  localparam logic       REFHI_RST      = 1'b1;

  // Gain codes of the channel settings register
  typedef enum logic [2:0] {
    SCD_GAIN_1  = 3'b000,
    SCD_GAIN_2  = 3'b001,
    SCD_GAIN_4  = 3'b010,
    SCD_GAIN_8  = 3'b011,
    SCD_GAIN_12 = 3'b100
  } scd_gain_t;

  localparam scd_gain_t GAIN_RST = SCD_GAIN_1;

  function automatic logic gain_legal(input logic [2:0] code);
    gain_legal = (code <= 3'(SCD_GAIN_12));
  endfunction : gain_legal

  // Aligns a sinc3 result to 24 bits and clamps it
  function automatic logic [OUT_W-1:0] scale_sat(input logic [ACC_W-1:0] acc, input logic [2:0] rate);
    logic signed [63:0] wide;
    wide = 64'(signed'(acc)) <<< ALIGN_SHIFT;
    wide = wide >>> (OCTAVE_SHIFT * int'(rate));
    if (wide > 64'sh0000_0000_007F_FFFF)
      scale_sat = 24'h7F_FFFF;
    else if (wide < -64'sh0000_0000_0080_0000)
      scale_sat = 24'h80_0000;
    else
      scale_sat = wide[OUT_W-1:0];
  endfunction : scale_sat

endpackage : scd_pkg

// [rtl/scd_sinc3.sv]
`timescale 1ns/10ps
module scd_sinc3 #(
  parameter int ACC_W = scd_pkg::ACC_W,
  parameter int OUT_W = scd_pkg::OUT_W
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             clear_in,
  input  wire logic             mod_tick_in,
  input  wire logic             dec_tick_in,
  input  wire logic             bit_in,
  input  wire logic [2:0]       rate_in,
  output logic      [OUT_W-1:0] sample_out
);

  // ----------------------------------------------------------------
  // Integrators at the modulator rate, combs at the output rate
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] int1, int2, int3;
  logic [ACC_W-1:0] dly1, dly2, dly3;
  logic [ACC_W-1:0] next_int1, next_int2, next_int3;
  logic [ACC_W-1:0] next_dly1, next_dly2, next_dly3;
  logic [OUT_W-1:0] next_sample;
  logic [ACC_W-1:0] c1, c2, c3, x;

  // Wrap-around arithmetic is exact because the result is bounded by N cubed
  always_comb
  begin
    x           = bit_in ? {{(ACC_W-1){1'b0}}, 1'b1} : {ACC_W{1'b1}};  // Bit maps to +1 or -1
    next_int1   = int1;
    next_int2   = int2;
    next_int3   = int3;
    next_dly1   = dly1;
    next_dly2   = dly2;
    next_dly3   = dly3;
    next_sample = sample_out;
    c1          = int3 - dly1;                                     // Each comb is 1 - z^-N
    c2          = c1 - dly2;
    c3          = c2 - dly3;
    if (mod_tick_in)
    begin
      next_int1 = int1 + x;                                        // Each integrator is 1/(1 - z^-1)
      next_int2 = int2 + int1;
      next_int3 = int3 + int2;
    end
    if (dec_tick_in)
    begin
      next_dly1   = int3;
      next_dly2   = c1;
      next_dly3   = c2;
      next_sample = scd_pkg::scale_sat(c3, rate_in);
    end
    if (clear_in)
    begin
      next_int1 = '0;
      next_int2 = '0;
      next_int3 = '0;
      next_dly1 = '0;
      next_dly2 = '0;
      next_dly3 = '0;
    end
  end

  // Filter state
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      int1       <= '0;
      int2       <= '0;
      int3       <= '0;
      dly1       <= '0;
      dly2       <= '0;
      dly3       <= '0;
      sample_out <= '0;
    end
    else
    begin
      int1       <= next_int1;
      int2       <= next_int2;
      int3       <= next_int3;
      dly1       <= next_dly1;
      dly2       <= next_dly2;
      dly3       <= next_dly3;
      sample_out <= next_sample;
    end
  end

endmodule : scd_sinc3

// [verif/scd_chk_sva.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port checker for clock select, register bus and sample strobe
// ----------------------------------------------------------------
module scd_chk #(
  parameter int CH_NUM = 8
) (
  input wire logic                sys_clk_in,
  input wire logic                rst_in,
  input wire logic [7:0]          avs_address_in,
  input wire logic                avs_read_in,
  input wire logic                avs_write_in,
  input wire logic [31:0]         avs_writedata_in,
  input wire logic [3:0]          avs_byteenable_in,
  input wire logic [31:0]         avs_readdata_out,
  input wire logic                avs_waitrequest_out,
  input wire logic                clock_source_select_pin_in,
  input wire logic                clk_pin_in,
  input wire logic                clk_pin_out,
  input wire logic                clk_pin_oe_out,
  input wire logic [CH_NUM-1:0]   mod_bit_in,
  input wire logic [3*CH_NUM-1:0] pga_gain_out,
  input wire logic                reference_high_select_out,
  input wire logic                sample_strobe_out
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [1:0] nrise;
  logic [1:0] next_nrise;
  logic       prev_out;
  logic       rise;
  logic       gain_ok;
  logic       ack;

  // Oscillator period count; the first rise after enable may be clipped, so two rises arm it
  always_comb
  begin
    rise = clk_pin_out && !prev_out;
    next_cnt = rise ? 8'h01 : cnt + {7'h00, cnt != 8'hFF};
    next_nrise = (rst_in || !clk_pin_oe_out) ? 2'h0 : nrise + {1'b0, rise && nrise != 2'h2};
    gain_ok = 1'b1;
    for (int i = 0; i < CH_NUM; i++)
      if (pga_gain_out[3*i+:3] > 3'h4)
        gain_ok = 1'b0;
  end

  always_ff @(posedge sys_clk_in)
  begin
    cnt <= next_cnt;
    nrise <= next_nrise;
    prev_out <= clk_pin_out;
  end

  assign ack = avs_write_in && !avs_waitrequest_out;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_ext_no_drive;
    !clock_source_select_pin_in [*4] |=> !clk_pin_oe_out;
  endproperty
  property p_pin_quiet;
    !clk_pin_oe_out |-> !clk_pin_out;
  endproperty
  property p_osc_period;
    rise && nrise == 2'h2 |-> cnt inside {8'h61, 8'h62};
  endproperty
  property p_strobe_gap;
    sample_strobe_out |=> !sample_strobe_out [*8];
  endproperty
  property p_gain_legal;
    gain_ok;
  endproperty
  property p_gain_on_write;
    !$stable(pga_gain_out) |-> $past(ack);
  endproperty
  property p_ref_on_write;
    !$stable(reference_high_select_out) |-> $past(ack);
  endproperty
  property p_answer_next;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  property p_wait_single;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty

  a_ext_no_drive: assert property (p_ext_no_drive)
    else $error("clock pin driven while external clock selected");
  a_pin_quiet: assert property (p_pin_quiet)
    else $error("clock pin toggles while released");
  a_osc_period: assert property (p_osc_period)
    else $error("oscillator period off nominal");
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("sample strobes too close");
  a_gain_legal: assert property (p_gain_legal)
    else $error("illegal gain code on pins");
  a_gain_on_write: assert property (p_gain_on_write)
    else $error("gain changed without a write");
  a_ref_on_write: assert property (p_ref_on_write)
    else $error("reference select changed without a write");
  a_answer_next: assert property (p_answer_next)
    else $error("bus answer late");
  a_wait_single: assert property (p_wait_single)
    else $error("waitrequest low too long");

  c_strobe: cover property (sample_strobe_out);
  c_drive: cover property ($rose(clk_pin_oe_out));
  c_write: cover property (ack);
  c_gain: cover property (!$stable(pga_gain_out));
endmodule : scd_chk

// [verif/scd_far_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// External clock source and clock pin wire
// ----------------------------------------------------------------
module scd_far_model (
  input  wire logic sys_clk_in,
  input  wire logic run_in,
  input  wire logic dev_clk_in,
  input  wire logic dev_oe_in,
  output logic      pin_level_out
);
  logic [1:0] ph = 2'h0;
  logic       ext_clk = 1'b0;

  // Toggles every third edge, so the period is six system cycles; frozen low when idle
  always @(posedge sys_clk_in)
  begin
    if (!run_in)
    begin
      ph <= 2'h0;
      ext_clk <= 1'b0;
    end
    else if (ph == 2'h2)
    begin
      ph <= 2'h0;
      ext_clk <= !ext_clk;
    end
    else
      ph <= ph + 2'h1;
  end

  // Device wins the wire while it drives; the bench stops the source first
  assign pin_level_out = dev_oe_in ? dev_clk_in : ext_clk;
endmodule : scd_far_model

// [verif/sinc3_decimator_clock_select_tb_top.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module sinc3_decimator_clock_select_tb_top;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wrq = 1'b0, sel = 1'b0, run = 1'b1;
  logic [7:0] addr = 8'h00, mod = 8'h00, mask;
  logic [31:0] wdata = 32'h0, q;
  logic [31:0] rdata;
  logic [23:0] gains, expv;
  logic waitreq, pin_out, pin_oe, ref_hi, stb, pin_lvl;
  int n_mismatch = 0, checks = 0, gm[8], n, ch, code;

  always #2.5 clk = !clk;

  scd_top i_scd_top (.sys_clk_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wrq), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .clock_source_select_pin_in(sel), .clk_pin_in(pin_lvl),
    .clk_pin_out(pin_out), .clk_pin_oe_out(pin_oe), .mod_bit_in(mod), .pga_gain_out(gains),
    .reference_high_select_out(ref_hi), .sample_strobe_out(stb));
  scd_far_model i_scd_far_model (.sys_clk_in(clk), .run_in(run), .dev_clk_in(pin_out), .dev_oe_in(pin_oe),
    .pin_level_out(pin_lvl));

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    addr <= a;
    wdata <= d;
    wrq <= we;
    rd <= !we;
    @(posedge clk);
    while (waitreq !== 1'b0 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 50)
      n_mismatch++;
    r = rdata;
    rd <= 1'b0;
    wrq <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(nm, e, r)
  endtask : rdchk

  // Counts cycles up to the next strobe, bounded
  task automatic wstb(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end while (stb !== 1'b1 && c < 40000);
    if (c >= 40000)
      n_mismatch++;
  endtask : wstb

  // Settled sinc3 word for a constant stream: +-N^3, aligned, then clamped to 24 bits
  function automatic logic [31:0] exp_word(input logic b, input int rate);
    longint v;
    v = 64'sh10 << rate;
    v = v * v * v * (b ? 1 : -1);
    v = (v <<< 11) >>> (3 * rate);
    if (v > 64'sh7F_FFFF)
      v = 64'sh7F_FFFF;
    if (v < -64'sh80_0000)
      v = -64'sh80_0000;
    return 32'(v);
  endfunction : exp_word

  task automatic datachk(input logic [7:0] m);
    int c;
    logic [31:0] r;
    repeat (4) wstb(c);
    for (int i = 0; i < 8; i++)
      rdchk(scd_pkg::OFS_DATA_BASE + 8'(4 * i), exp_word(m[i], 0), "data");
    bus(1'b0, scd_pkg::OFS_STAT, 32'h0, r);
    `CHK("settled", 1'b1, r[0])
  endtask : datachk

  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    results();
  end

  // Main sequence: registers, gains, rates on the external clock, then the oscillator
  initial
  begin
    void'($urandom(32'h0276));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("gain_pins", 24'h0, gains)
    `CHK("ref_pin", 1'b1, ref_hi)
    rdchk(scd_pkg::OFS_CFG1, 32'h0000_0006, "cfg1");
    rdchk(scd_pkg::OFS_CFG2, 32'h0000_0010, "cfg2");
    rdchk(8'h0C, 32'h0000_0000, "unmapped");
    for (int k = 0; k < 24; k++)
    begin
      ch = $urandom % 8;
      code = (k < 5) ? k : $urandom % 8;
      wr(scd_pkg::OFS_CHSET_BASE + 8'(4 * ch), 32'(code) << 4);
      if (code <= 4)
        gm[ch] = code;
      for (int i = 0; i < 8; i++)
        expv[3*i+:3] = 3'(gm[i]);
      `CHK("gain", expv, gains)
      rdchk(scd_pkg::OFS_CHSET_BASE + 8'(4 * ch), 32'(gm[ch]) << 4, "chset");
    end
    wr(scd_pkg::OFS_CFG2, 32'h0000_0000);
    `CHK("ref_low", 1'b0, ref_hi)
    wr(scd_pkg::OFS_CFG2, 32'h0000_0010);
    `CHK("ref_high", 1'b1, ref_hi)
    mask = 8'($urandom);
    mod <= mask;
    for (int rate = 0; rate < 7; rate++)
    begin
      wr(scd_pkg::OFS_CFG1, 32'(rate));
      wstb(n);
      wstb(n);
      `CHK("word_gap", 12 * (16 << rate), n)
      if (rate == 0)
      begin
        datachk(mask);
        mod <= ~mask;
        datachk(~mask);
      end
    end
    wr(scd_pkg::OFS_CFG1, 32'h0000_0027);
    rdchk(scd_pkg::OFS_CFG1, 32'h0000_0026, "rate_reserved");
    `CHK("oe_ext", 1'b0, pin_oe)
    run <= 1'b0;
    sel <= 1'b1;
    wr(scd_pkg::OFS_CFG1, 32'h0000_0020);
    repeat (8) @(posedge clk);
    `CHK("oe_int", 1'b1, pin_oe)
    bus(1'b0, scd_pkg::OFS_STAT, 32'h0, q);
    `CHK("src_int", 1'b1, q[1])
    wstb(n);
    wstb(n);
    `CHK("osc_gap", 1'b1, n >= 3123 && n <= 3127)
    wr(scd_pkg::OFS_CFG1, 32'h0000_0000);
    repeat (4) @(posedge clk);
    `CHK("oe_off", 1'b0, pin_oe)
    results();
  end
endmodule : sinc3_decimator_clock_select_tb_top

bind scd_top scd_chk #(.CH_NUM(CH_NUM)) i_scd_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .clock_source_select_pin_in(clock_source_select_pin_in), .clk_pin_in(clk_pin_in),
  .clk_pin_out(clk_pin_out), .clk_pin_oe_out(clk_pin_oe_out), .mod_bit_in(mod_bit_in),
  .pga_gain_out(pga_gain_out), .reference_high_select_out(reference_high_select_out),
  .sample_strobe_out(sample_strobe_out));
